/* pkg/tz_defines.svh */
`ifndef TZ_DEFINES_SVH
`define TZ_DEFINES_SVH
// ----------------------------------------------------------------
// Register map: word index, byte address is four times the index
// ----------------------------------------------------------------
`define TZ_ADDR_W       16
`define TZ_IDX_LOW      14'h0fd2
`define TZ_IDX_HIGH     14'h0fd3
`define TZ_IDX_CON0     14'h0fd4
`define TZ_IDX_CON1     14'h0fd5
`define TZ_SEL_LOW      2'h0
`define TZ_SEL_HIGH     2'h1
`define TZ_SEL_CON0     2'h2
`define TZ_SEL_CON1     2'h3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TZ_RST_LOW      8'h00
`define TZ_RST_HIGH     8'hff
`define TZ_RST_DIV      4'h0
`define TZ_RST_SRC      3'h0
// ----------------------------------------------------------------
// Bus answers and widths
// ----------------------------------------------------------------
`define TZ_RESP_OKAY    2'b00
`define TZ_RESP_SLVERR  2'b10
`define TZ_PSC_W        15
`define TZ_WIDE_MAX     16'hffff
`define TZ_BYTE_MAX     8'hff
// ----------------------------------------------------------------
// Asynchronous counting inputs, bit positions in the synchroniser
// ----------------------------------------------------------------
`define TZ_NIN          4
`define TZ_IN_PIN       0
`define TZ_IN_FAST      1
`define TZ_IN_SLOW      2
`define TZ_IN_SEC       3
`endif

/* pkg/tz_pkg.sv */
`default_nettype none
package tz_pkg;
  // Counting source codes
  typedef enum logic [2:0]
  {
    TZ_SRC_PIN     = 3'b000,
    TZ_SRC_PIN_INV = 3'b001,
    TZ_SRC_ICLK    = 3'b010,
    TZ_SRC_FAST    = 3'b011,
    TZ_SRC_SLOW    = 3'b100,
    TZ_SRC_SEC     = 3'b101,
    TZ_SRC_RSV6    = 3'b110,
    TZ_SRC_RSV7    = 3'b111
  } tz_src_t;

  // First control byte as software sees it
  typedef struct packed
  {
    logic       timer_run_enable;
    logic       unused_bit;
    logic       output_level_status;
    logic       wide_count_select;
    logic [3:0] output_divider_field;
  } tz_con0_t;

  // Second control byte
  typedef struct packed
  {
    tz_src_t    count_source_field;
    logic       unsync_input_enable;
    logic [3:0] input_divider_field;
  } tz_con1_t;
endpackage : tz_pkg
`default_nettype wire

/* logic/tz_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tz_defines.svh"
module tz_prescaler
  import tz_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clr,
  input  wire logic                 edge_in,
  input  wire logic [3:0]           ratio,
  output logic                      tick
);
  logic [`TZ_PSC_W-1:0] cnt_q;  // Hidden divider count
  logic [`TZ_PSC_W-1:0] mask;   // Terminal count, 2^ratio - 1

  // Terminal count from the field
  assign mask = `TZ_PSC_W'((16'h0001 << ratio) - 16'h0001);
  assign tick = edge_in & (cnt_q == mask);

  // Divider count, cleared by software side effects
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (clr)
      cnt_q <= '0;
    else if (edge_in)
      cnt_q <= tick ? '0 : cnt_q + `TZ_PSC_W'(1);
  end

  a_psc_clear : assert property (@(posedge aclk) disable iff (!aresetn)
    clr |=> cnt_q == '0)
    else $error("prescaler not cleared");
endmodule : tz_prescaler
`default_nettype wire

/* logic/tz_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tz_defines.svh"
// What this block does
// - Enable bit seven runs or stops timer
// - Bit five reads live output level
// - Bit four picks sixteen or eight bit
// - Output divider divides events by field+1
// - Source field selects the counting clock
// - Unsync bit bypasses instruction clock synchronisation
// - Prescaler divides by two to field
// - Eight bit: low restarts at period
// - Sixteen bit: high and low form count
// - Eight bit: low holds live count
// - Reset: high and period buffer all ones, others zero
// - Eight bit: match clears low, reloads period buffer
// - Sixteen bit: low read/write moves high atomically
// - Output toggles per scaled event, flags
// - Low and control writes and reset clear both dividers
module tz_timer
  import tz_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`TZ_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`TZ_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  count_pin,
  input  wire logic                  fast_osc,
  input  wire logic                  slow_osc,
  input  wire logic                  sec_osc,
  output logic                       timer_out,
  output logic                       timer_event_flag_set
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Returns {hit, select}; low two address bits must be zero
  function automatic logic [2:0] reg_sel(input logic [`TZ_ADDR_W-1:0] addr);
    logic [13:0] idx;
    logic        hit;
    idx = addr[`TZ_ADDR_W-1:2];
    hit = (addr[1:0] == 2'h0) && (idx >= `TZ_IDX_LOW) && (idx <= `TZ_IDX_CON1);
    reg_sel = {hit, 2'(idx - `TZ_IDX_LOW)};
  endfunction : reg_sel

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        bvalid_q;        // Write answer pending
  logic [1:0]  bresp_q;         // Write answer code
  logic        rvalid_q;        // Read answer pending
  logic [1:0]  rresp_q;         // Read answer code
  logic [31:0] rdata_q;         // Read answer data
  logic        wr_go;           // Write address and data taken
  logic        rd_go;           // Read address taken
  logic [2:0]  wsel;            // Write decode
  logic [2:0]  rsel;            // Read decode
  logic        wr_lo;           // Write to count low byte
  logic        wr_hi;           // Write to high byte
  logic        wr_c0;           // Write to first control
  logic        wr_c1;           // Write to second control
  logic        rd_lo;           // Read of count low byte
  logic        en_q;            // Run enable
  logic        wide_q;          // Sixteen bit select
  logic [3:0]  div_q;           // Output divider field
  tz_src_t     src_q;           // Counting source
  logic        unsync_q;        // Bypass extra sync stage
  logic [3:0]  psc_q;           // Prescaler field
  logic [7:0]  low_q;           // Live low count
  logic [7:0]  high_q;          // Software high byte register
  logic [7:0]  hi_live_q;       // Live high count, wide mode
  logic [7:0]  pbuf_q;          // Buffered period copy
  logic [3:0]  post_q;          // Hidden output divider count
  logic        out_q;           // Timer output level
  logic        flag_q;          // Event flag set pulse
  logic [`TZ_NIN-1:0] sync1_q;  // First synchroniser stage
  logic [`TZ_NIN-1:0] sync2_q;  // Second synchroniser stage
  logic        src_lvl;         // Selected source level
  logic        stage_q;         // Instruction clock alignment stage
  logic        lvl_sel;         // Level fed to edge detect
  logic        prev_q;          // Previous level
  logic        src_edge;        // Rising edge of source
  logic        div_clr;         // Clear both dividers
  logic        tick;            // Prescaled count step
  logic        match;           // Low equals buffered period
  logic        event_hit;       // Match or rollover
  logic        post_end;        // Output divider terminal
  tz_con0_t    con0_rd;         // First control read view
  tz_con1_t    con1_rd;         // Second control read view

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together; one write in flight
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~rvalid_q;
  assign s_axi_arready = rd_go;
  assign wsel          = reg_sel(s_axi_awaddr);
  assign rsel          = reg_sel(s_axi_araddr);
  // Byte lane zero carries every register
  assign wr_lo = wr_go & wsel[2] & s_axi_wstrb[0] & (wsel[1:0] == `TZ_SEL_LOW);
  assign wr_hi = wr_go & wsel[2] & s_axi_wstrb[0] & (wsel[1:0] == `TZ_SEL_HIGH);
  assign wr_c0 = wr_go & wsel[2] & s_axi_wstrb[0] & (wsel[1:0] == `TZ_SEL_CON0);
  assign wr_c1 = wr_go & wsel[2] & s_axi_wstrb[0] & (wsel[1:0] == `TZ_SEL_CON1);
  assign rd_lo = rd_go & rsel[2] & (rsel[1:0] == `TZ_SEL_LOW);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // Write answer; unmapped address gets a slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `TZ_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wsel[2] ? `TZ_RESP_OKAY : `TZ_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // Read views; reserved bit six reads zero
  assign con0_rd = '{en_q, 1'b0, out_q, wide_q, div_q};
  assign con1_rd = '{src_q, unsync_q, psc_q};

  // Read answer, data held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `TZ_RESP_OKAY;
      rdata_q  <= '0;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rsel[2] ? `TZ_RESP_OKAY : `TZ_RESP_SLVERR;
      unique case (rsel[1:0])
        `TZ_SEL_LOW  : rdata_q <= {24'h0, low_q};
        `TZ_SEL_HIGH : rdata_q <= {24'h0, high_q};
        `TZ_SEL_CON0 : rdata_q <= {24'h0, con0_rd};
        `TZ_SEL_CON1 : rdata_q <= {24'h0, con1_rd};
      endcase
      if (!rsel[2])
        rdata_q <= '0;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // First control: enable, width, output divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q   <= 1'b0;
      wide_q <= 1'b0;
      div_q  <= `TZ_RST_DIV;
    end
    else if (wr_c0)
    begin
      en_q   <= s_axi_wdata[7];
      wide_q <= s_axi_wdata[4];
      div_q  <= s_axi_wdata[3:0];
    end
  end

  // Second control: source, sync bypass, prescaler
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_q    <= TZ_SRC_PIN;
      unsync_q <= 1'b0;
      psc_q    <= `TZ_RST_DIV;
    end
    else if (wr_c1)
    begin
      src_q    <= tz_src_t'(s_axi_wdata[7:5]);
      unsync_q <= s_axi_wdata[4];
      psc_q    <= s_axi_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Counting source
  // ----------------------------------------------------------------
  // Every outside input passes two flops before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {sec_osc, slow_osc, fast_osc, count_pin};
      sync2_q <= sync1_q;
    end
  end

  // Source select; reserved codes never count
  always_comb
  begin
    src_lvl = 1'b0;
    unique case (src_q)
      TZ_SRC_PIN     : src_lvl = sync2_q[`TZ_IN_PIN];
      TZ_SRC_PIN_INV : src_lvl = ~sync2_q[`TZ_IN_PIN];
      TZ_SRC_FAST    : src_lvl = sync2_q[`TZ_IN_FAST];
      TZ_SRC_SLOW    : src_lvl = sync2_q[`TZ_IN_SLOW];
      TZ_SRC_SEC     : src_lvl = sync2_q[`TZ_IN_SEC];
      TZ_SRC_ICLK    : src_lvl = 1'b0;
      TZ_SRC_RSV6    : src_lvl = 1'b0;
      TZ_SRC_RSV7    : src_lvl = 1'b0;
    endcase
  end

  // Synchronous mode adds one instruction clock stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stage_q <= 1'b0;
    else
      stage_q <= src_lvl;
  end

  // Switching the bypass may skip or add one count
  assign lvl_sel = unsync_q ? src_lvl : stage_q;

  // Edge detector on the chosen level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_q <= 1'b0;
    else
      prev_q <= lvl_sel;
  end

  // Instruction clock counts on every cycle
  assign src_edge = (src_q == TZ_SRC_ICLK) | (lvl_sel & ~prev_q);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign div_clr = wr_lo | wr_c0 | wr_c1;

  // Disabled timer feeds no edges, so the divider holds
  tz_prescaler u_psc
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (div_clr),
    .edge_in (src_edge & en_q),
    .ratio   (psc_q),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign match     = (low_q == pbuf_q);
  assign event_hit = tick & ~wr_lo & (wide_q ? ({hi_live_q, low_q} == `TZ_WIDE_MAX) : match);

  // Live low byte; software write wins over a step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_q <= `TZ_RST_LOW;
    else if (wr_lo)
      low_q <= s_axi_wdata[7:0];
    else if (tick & ~wide_q & match)
      low_q <= `TZ_RST_LOW;
    else if (tick)
      low_q <= low_q + 8'h01;
  end

  // Live high byte, stepped on low rollover
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hi_live_q <= `TZ_RST_LOW;
    else if (wr_lo & wide_q)
      hi_live_q <= high_q;
    else if (tick & wide_q & (low_q == `TZ_BYTE_MAX))
      hi_live_q <= hi_live_q + 8'h01;
  end

  // Software high byte; a write beats the read capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      high_q <= `TZ_RST_HIGH;
    else if (wr_hi)
      high_q <= s_axi_wdata[7:0];
    else if (rd_lo & wide_q)
      high_q <= hi_live_q;
  end

  // Period buffer, refreshed only on a match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pbuf_q <= `TZ_RST_HIGH;
    else if (tick & ~wide_q & match & ~wr_lo)
      pbuf_q <= high_q;
  end

  // ----------------------------------------------------------------
  // Output divider and output
  // ----------------------------------------------------------------
  assign post_end = event_hit & (post_q == div_q);

  // Hidden event count, field plus one events per toggle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      post_q <= `TZ_RST_DIV;
    else if (div_clr)
      post_q <= `TZ_RST_DIV;
    else if (post_end)
      post_q <= `TZ_RST_DIV;
    else if (event_hit)
      post_q <= post_q + 4'h1;
  end

  // Output level and its flag pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_q  <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      out_q  <= out_q ^ post_end;
      flag_q <= post_end;
    end
  end

  assign timer_out            = out_q;
  assign timer_event_flag_set = flag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Output divider back at its start value
  sequence s_post_idle;
    post_q == `TZ_RST_DIV;
  endsequence

  a_disabled_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    (!en_q && !wr_lo) |=> ($stable(low_q) && $stable(out_q) && !flag_q))
    else $error("disabled timer moved");

  a_match_clear : assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !wide_q && match && !wr_lo) |=> (low_q == `TZ_RST_LOW))
    else $error("low not cleared on match");

  a_period_reload : assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !wide_q && match && !wr_lo) |=> (pbuf_q == $past(high_q)))
    else $error("period buffer not refreshed");

  a_wide_roll : assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && wide_q && !wr_lo && ({hi_live_q, low_q} == `TZ_WIDE_MAX))
      |=> ({hi_live_q, low_q} == 16'h0000))
    else $error("wide count did not roll over");

  a_count_step : assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !match && !wr_lo) |=> (low_q == $past(low_q) + 8'h01))
    else $error("low count did not step");

  a_toggle_flag : assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(out_q) |-> flag_q)
    else $error("output toggled without flag");

  a_low_capture : assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_lo && wide_q && !wr_hi) |=> (high_q == $past(hi_live_q)))
    else $error("high byte not captured on low read");

  a_low_load : assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lo && wide_q) |=> (hi_live_q == $past(high_q)) && (low_q == $past(s_axi_wdata[7:0])))
    else $error("atomic write failed");

  a_post_clear : assert property (@(posedge aclk) disable iff (!aresetn)
    div_clr |=> s_post_idle)
    else $error("output divider not cleared");

  a_post_bound : assert property (@(posedge aclk) disable iff (!aresetn)
    (en_q && !div_clr) |-> (post_q <= div_q))
    else $error("output divider ran past field");
endmodule : tz_timer
`default_nettype wire

/* dv/tz_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tz_defines.svh"
// ----------------------------------------
// Compare helper, counts every comparison
// ----------------------------------------
`define CHK(act, exp) \
  begin \
    samples_checked++; \
    if ((act) !== (exp)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED %0t got %0h expected %0h", $time, act, exp); \
    end \
  end
module tb
  import tz_pkg::*;
;
  // ----------------------------------------
  // Bus, counting inputs and bench state
  // ----------------------------------------
  logic        aclk, aresetn;                 // Clock and low-active reset
  logic [15:0] s_axi_awaddr, s_axi_araddr;    // Byte addresses
  logic [2:0]  s_axi_awprot, s_axi_arprot;    // Random, ignored by the block
  logic        s_axi_awvalid, s_axi_awready;  // Write address handshake
  logic [31:0] s_axi_wdata, s_axi_rdata;      // Data words
  logic [3:0]  s_axi_wstrb;                   // Byte lanes
  logic        s_axi_wvalid, s_axi_wready;    // Write data handshake
  logic [1:0]  s_axi_bresp, s_axi_rresp;      // Answers
  logic        s_axi_bvalid, s_axi_bready;    // Write answer handshake
  logic        s_axi_arvalid, s_axi_arready;  // Read address handshake
  logic        s_axi_rvalid, s_axi_rready;    // Read answer handshake
  logic        count_pin, fast_osc;           // Slow square waves from cyc
  logic        slow_osc, sec_osc;
  logic        timer_out, timer_event_flag_set;
  logic [7:0]  cyc;                           // Free cycle count for sources
  logic        lvl;                           // Expected output level
  logic [33:0] rq[$];                         // Expected {rresp, rdata}
  logic [1:0]  bq[$];                         // Expected bresp
  int          gq[$];                         // Expected flag spacing
  int          gap, fl_cnt, error_cnt, samples_checked, seed, n;
  logic [33:0] rexp;                          // Oldest read note
  logic [1:0]  bexp;                          // Oldest write note
  int          gexp;                          // Oldest spacing note
  logic [7:0]  h;                             // Random period byte
  logic [7:0]  c1 [8] = '{8'h40, 8'h43, 8'h51, 8'h00, 8'h30, 8'h60, 8'h80, 8'ha1};
  int          dv [8] = '{0, 1, 15, 0, 2, 0, 1, 0};
  int          sp [8] = '{1, 1, 1, 8, 8, 4, 16, 32};  // aclk cycles per source edge

  tz_timer tz_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .count_pin(count_pin), .fast_osc(fast_osc), .slow_osc(slow_osc), .sec_osc(sec_osc),
    .timer_out(timer_out), .timer_event_flag_set(timer_event_flag_set));

  // ----------------------------------------
  // Clock and source waveforms
  // ----------------------------------------
  always #4 aclk = ~aclk;
  // Distinct periods let each source be told apart by flag spacing
  always @(posedge aclk)
  begin
    cyc       <= cyc + 8'h01;
    count_pin <= cyc[2];
    fast_osc  <= cyc[1];
    slow_osc  <= cyc[3];
    sec_osc   <= cyc[4];
  end

  // ----------------------------------------
  // Monitor: pops the oldest note per result
  // ----------------------------------------
  always @(posedge aclk)
  begin
    gap <= gap + 1;
    // Pop once into a note, the compare macro reads its argument twice
    if (s_axi_rvalid && s_axi_rready)
    begin
      rexp = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, rexp)
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bexp = bq.pop_front();
      `CHK(s_axi_bresp, bexp)
    end
    if (timer_event_flag_set === 1'b1)
    begin
      lvl = ~lvl;
      `CHK(timer_out, lvl)
      fl_cnt++;
      gap <= 1;
      if (gq.size() > 0)
      begin
        gexp = gq.pop_front();
        `CHK(gap, gexp)
      end
    end
  end

  // ----------------------------------------
  // Bus tasks, one transfer at a time
  // ----------------------------------------
  // Valids are held until the edge after ready is seen settled
  task automatic wr(input logic [13:0] idx, input logic [7:0] d,
                    input logic [3:0] st = 4'hf, input logic [1:0] er = `TZ_RESP_OKAY);
    bq.push_back(er);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awprot  <= 3'($random(seed));
    s_axi_wdata   <= {24'($random(seed)), d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    // Each channel drops its valid at the edge that takes it
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask : wr

  task automatic rd(input logic [13:0] idx, input logic [7:0] e,
                    input logic [1:0] er = `TZ_RESP_OKAY);
    rq.push_back({er, 24'h0, e});
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arprot  <= 3'($random(seed));
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
  endtask : rd

  // Waits for a number of further flag pulses
  task automatic flags(input int k);
    int t;
    t = fl_cnt + k;
    while (fl_cnt < t) @(posedge aclk);
  endtask : flags

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Watchdog, far beyond the expected run
  // ----------------------------------------
  initial
  begin
    repeat (60000) @(posedge aclk);
    $display("CHECK FAILED %0t watchdog expired", $time);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cyc} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {count_pin, fast_osc, slow_osc, sec_osc, lvl, s_axi_wstrb} = '0;
    {gap, fl_cnt, error_cnt, samples_checked} = '0;
    s_axi_bready = 1'b1;  // Always ready for answers
    s_axi_rready = 1'b1;
    seed = 27;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, unmapped places answer with an error
    rd(`TZ_IDX_LOW, `TZ_RST_LOW);
    rd(`TZ_IDX_HIGH, `TZ_RST_HIGH);
    rd(`TZ_IDX_CON0, 8'h00);
    rd(`TZ_IDX_CON1, 8'h00);
    rd(14'h0fd6, 8'h00, `TZ_RESP_SLVERR);
    wr(14'h0fd1, 8'h55, 4'hf, `TZ_RESP_SLVERR);
    // Control two is plain storage, lane 0 gates the write
    h = 8'($random(seed));
    wr(`TZ_IDX_CON1, h);
    wr(`TZ_IDX_CON1, ~h, 4'he);
    rd(`TZ_IDX_CON1, h);
    // Bit 6 reads zero, output level cannot be written
    wr(`TZ_IDX_CON0, 8'h6f);
    rd(`TZ_IDX_CON0, 8'h0f);
    // Flag spacing for every counting source, with dividers 0, 1, 2, 15 and ratios 0, 1, 3
    for (int i = 0; i < 8; i++)
    begin
      h = 8'(($random(seed) & 3) + 1);
      wr(`TZ_IDX_HIGH, h);
      wr(`TZ_IDX_CON1, c1[i]);
      wr(`TZ_IDX_CON0, {4'h8, 4'(dv[i])});
      flags(2);  // Old period buffer and cleared dividers settle first
      gq.push_back((h + 1) * (1 << c1[i][3:0]) * sp[i] * (dv[i] + 1));
      while (gq.size() > 0) @(posedge aclk);
    end
    // Reserved source never counts
    wr(`TZ_IDX_CON1, 8'hc0);
    repeat (20) @(posedge aclk);
    n = fl_cnt;
    repeat (300) @(posedge aclk);
    `CHK(fl_cnt, n)
    // Disabled timer holds count and level
    wr(`TZ_IDX_CON0, 8'h00);
    wr(`TZ_IDX_CON1, 8'h40);
    rd(`TZ_IDX_CON0, {2'b00, lvl, 5'h00});
    wr(`TZ_IDX_LOW, 8'h5a);
    repeat (50) @(posedge aclk);
    rd(`TZ_IDX_LOW, 8'h5a);
    `CHK(fl_cnt, n)
    // Wide mode: high moves through its buffer on low accesses
    wr(`TZ_IDX_CON0, 8'h10);
    wr(`TZ_IDX_HIGH, 8'h12);
    wr(`TZ_IDX_LOW, 8'h34);
    wr(`TZ_IDX_HIGH, 8'h77);
    rd(`TZ_IDX_HIGH, 8'h77);
    rd(`TZ_IDX_LOW, 8'h34);
    rd(`TZ_IDX_HIGH, 8'h12);
    // Rollover from near the top gives one toggle
    wr(`TZ_IDX_HIGH, 8'hff);
    wr(`TZ_IDX_LOW, 8'hfe);
    wr(`TZ_IDX_CON0, 8'h90);
    flags(1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
